// ### rtl/gbrf_pkg.sv
// Shared constants, types and tables for the gyro bias and rate block.
`default_nettype none
package gbrf_pkg;
  // Register byte offsets on the serial register port.
  localparam logic [7:0] ADDR_Y_BIAS_HI = 8'h15;
  localparam logic [7:0] ADDR_Y_BIAS_LO = 8'h16;
  localparam logic [7:0] ADDR_Z_BIAS_HI = 8'h17;
  localparam logic [7:0] ADDR_Z_BIAS_LO = 8'h18;
  localparam logic [7:0] ADDR_RATE_DIV = 8'h19;
  localparam logic [7:0] ADDR_FILT_CFG = 8'h1a;
  localparam logic [7:0] ADDR_GYRO_CFG = 8'h1b;
  // Value of every register after reset.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions in the filter and sync configuration register.
  localparam int FIFO_MODE_BIT = 6;
  localparam int SYNC_SEL_HI = 5;
  localparam int SYNC_SEL_LO = 3;
  localparam int LPF_SEL_HI = 2;
  localparam int LPF_SEL_LO = 0;
  // Field position of the bypass bits in the gyro configuration register.
  localparam int BYPASS_HI = 1;
  localparam int BYPASS_LO = 0;
  // Internal sample rate and the cycles of the system clock per sample.
  localparam int CLK_HZ = 125000000;
  localparam int INT_RATE_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / INT_RATE_HZ;
  // Sample channels in result order.
  localparam int NUM_CH = 7;
  localparam int CH_TEMP = 0;
  localparam int CH_ROT_X = 1;
  localparam int CH_ROT_Y = 2;
  localparam int CH_ROT_Z = 3;
  // Filter select values at which the divider stays inactive.
  localparam logic [2:0] LPF_WIDE = 3'h7;
  localparam logic [2:0] LPF_FIRST = 3'h0;
  // Bandwidths in Hz for the bypass cases and the filter settings 7..0.
  localparam logic [13:0] GYRO_BW_BYPASS = 14'd8173;
  localparam logic [13:0] GYRO_BW_WIDE = 14'd3281;
  localparam logic [11:0] TEMP_BW_WIDE = 12'd4000;
  localparam logic [7:0][13:0] GYRO_BW_TAB = {14'd3281, 14'd5, 14'd10,
    14'd20, 14'd41, 14'd92, 14'd176, 14'd250};
  localparam logic [7:0][11:0] TEMP_BW_TAB = {12'd4000, 12'd5, 12'd10,
    12'd20, 12'd42, 12'd98, 12'd188, 12'd4000};
  // Where the frame-sync level is tagged into the results.
  typedef enum logic [2:0] {
    SYNC_OFF = 3'h0, SYNC_TEMP = 3'h1, SYNC_ROT_X = 3'h2, SYNC_ROT_Y = 3'h3,
    SYNC_ROT_Z = 3'h4, SYNC_LIN_X = 3'h5, SYNC_LIN_Y = 3'h6,
    SYNC_LIN_Z = 3'h7
  } gbrf_sync_e;
  // One register port access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gbrf_reg_req_s;
  // One raw sample set, channel index as above.
  typedef logic [NUM_CH-1:0][15:0] gbrf_frame_t;
endpackage
`default_nettype wire

// ### rtl/gbrf_channel.sv
// One result channel: bias addition and frame-sync tagging.
`default_nettype none
module gbrf_channel #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Sample in.
  input wire logic load,
  input wire logic [W-1:0] raw,
  input wire logic [W-1:0] bias,
  input wire logic tag_en,
  input wire logic tag_bit,
  // Result out.
  output logic [W-1:0] result_r
);
  logic [W-1:0] sum;

  // Two's-complement sum wraps at the word width.
  assign sum = raw + bias; // [RULE2]

  // Store the corrected sample, with bit 0 replaced when tagged.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_r <= '0;
    end
    else if (load)
    begin
      result_r <= {sum[W-1:1], tag_en ? tag_bit : sum[0]}; // [RULE7]
    end
  end
endmodule
`default_nettype wire

// ### rtl/gbrf_top.sv
// Gyro bias, output rate, filter selection and frame-sync tagging.
`default_nettype none
// Overview of operation
// RULE1 - Bias is 16 bits across high, low bytes.
// RULE2 - Bias is added to sample before storing.
// RULE3 - Divided rate updates results and writes FIFO.
// RULE4 - Output rate is 1 kHz over divider plus one.
// RULE5 - Divider acts only unbypassed, select between 0,7.
// RULE6 - Bit 6 picks dropping or keeping writes when full.
// RULE7 - Sync select chooses result bit 0 for frame-sync.
// RULE8 - Filter select used only when bypass bits zero.
// RULE9 - Bypass bits give wide fixed bandwidths.
// RULE10 - Select value sets gyro and temperature bandwidth.
// RULE11 - Bypass bits are inverted filter choice.
// RULE12 - Without divider, native filter rate drives updates.
module gbrf_top
  import gbrf_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port.
  input wire gbrf_pkg::gbrf_reg_req_s REG_REQ,
  output logic [7:0] RD_DATA,
  // Raw samples from the filter stage.
  input wire logic SAMPLE_VALID,
  input wire gbrf_pkg::gbrf_frame_t SAMPLE_RAW,
  // Frame-sync pin.
  input wire logic FRAME_SYNC_INPUT,
  // FIFO write side.
  input wire logic FIFO_FULL,
  output logic FIFO_WR,
  output gbrf_pkg::gbrf_frame_t FIFO_DATA,
  // Result registers.
  output gbrf_pkg::gbrf_frame_t RESULT,
  // Filter settings.
  output logic [13:0] GYRO_BW_HZ,
  output logic [11:0] TEMP_BW_HZ
);
  import gbrf_pkg::*;
  logic [15:0] y_bias_r;
  logic [15:0] z_bias_r;
  logic [7:0] rate_div_r;
  logic [7:0] filt_cfg_r;
  logic [1:0] bypass_r;
  logic [7:0] rd_data_r;
  logic [2:0] fs_sync_r;
  logic fs_level_r;
  gbrf_frame_t frame_r;
  gbrf_frame_t bias_vec;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [7:0] div_cnt_r;
  logic div_eff;
  logic stb_r;
  logic fifo_wr_r;
  logic [13:0] gyro_bw_r;
  logic [11:0] temp_bw_r;
  logic [2:0] lpf_sel;
  gbrf_sync_e sync_sel;
  logic fifo_keep;
  assign lpf_sel = filt_cfg_r[LPF_SEL_HI:LPF_SEL_LO];
  assign sync_sel = gbrf_sync_e'(filt_cfg_r[SYNC_SEL_HI:SYNC_SEL_LO]);
  assign fifo_keep = filt_cfg_r[FIFO_MODE_BIT];
  // Register writes; the top bit of the filter register always reads 0.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      y_bias_r <= {REG_RESET, REG_RESET};
      z_bias_r <= {REG_RESET, REG_RESET};
      rate_div_r <= REG_RESET;
      filt_cfg_r <= REG_RESET;
      bypass_r <= REG_RESET[1:0];
    end
    else if (REG_REQ.wr)
    begin
      case (REG_REQ.addr)
        ADDR_Y_BIAS_HI: y_bias_r[15:8] <= REG_REQ.wdata; // [RULE1]
        ADDR_Y_BIAS_LO: y_bias_r[7:0] <= REG_REQ.wdata; // [RULE1]
        ADDR_Z_BIAS_HI: z_bias_r[15:8] <= REG_REQ.wdata; // [RULE1]
        ADDR_Z_BIAS_LO: z_bias_r[7:0] <= REG_REQ.wdata; // [RULE1]
        ADDR_RATE_DIV: rate_div_r <= REG_REQ.wdata;
        ADDR_FILT_CFG: filt_cfg_r <= {1'b0, REG_REQ.wdata[6:0]};
        ADDR_GYRO_CFG: bypass_r <= REG_REQ.wdata[BYPASS_HI:BYPASS_LO];
        default: ;
      endcase
    end
  end
  // Registered read data; unmapped offsets read zero.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_data_r <= REG_RESET;
    end
    else if (REG_REQ.rd)
    begin
      case (REG_REQ.addr)
        ADDR_Y_BIAS_HI: rd_data_r <= y_bias_r[15:8];
        ADDR_Y_BIAS_LO: rd_data_r <= y_bias_r[7:0];
        ADDR_Z_BIAS_HI: rd_data_r <= z_bias_r[15:8];
        ADDR_Z_BIAS_LO: rd_data_r <= z_bias_r[7:0];
        ADDR_RATE_DIV: rd_data_r <= rate_div_r;
        ADDR_FILT_CFG: rd_data_r <= filt_cfg_r;
        ADDR_GYRO_CFG: rd_data_r <= {6'h00, bypass_r};
        default: rd_data_r <= REG_RESET;
      endcase
    end
  end
  assign RD_DATA = rd_data_r;
  // Frame-sync pin synchroniser; the level moves once stages 2 and 3 agree.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fs_sync_r <= 3'h0;
      fs_level_r <= 1'b0;
    end
    else
    begin
      fs_sync_r <= {fs_sync_r[1:0], FRAME_SYNC_INPUT};
      if (fs_sync_r[2] == fs_sync_r[1])
      begin
        fs_level_r <= fs_sync_r[2];
      end
    end
  end
  // Hold the latest raw sample set from the filter stage.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      frame_r <= '0;
    end
    else if (SAMPLE_VALID)
    begin
      frame_r <= SAMPLE_RAW;
    end
  end
  // Divider counts only with no bypass and a mid-range filter select.
  assign div_eff = (bypass_r == 2'b00) && (lpf_sel != LPF_FIRST)
                   && (lpf_sel != LPF_WIDE); // [RULE5] [RULE11]
  // Internal 1 kHz tick from the system clock.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? 32'h0
                    : tick_cnt_r + 32'h1;
    end
  end
  // Output strobe: every (divider+1)th tick, else the native sample rate.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      div_cnt_r <= 8'h00;
      stb_r <= 1'b0;
    end
    else if (div_eff)
    begin
      stb_r <= tick_r && (div_cnt_r == 8'h00); // [RULE4]
      if (tick_r)
      begin
        div_cnt_r <= (div_cnt_r == 8'h00) ? rate_div_r
                     : div_cnt_r - 8'h01; // [RULE4]
      end
    end
    else
    begin
      stb_r <= SAMPLE_VALID; // [RULE12]
      div_cnt_r <= 8'h00;
    end
  end
  // Bias per channel; only the Y and Z gyro axes carry one here.
  always_comb
  begin
    bias_vec = '0;
    bias_vec[CH_ROT_Y] = y_bias_r;
    bias_vec[CH_ROT_Z] = z_bias_r;
  end
  // Result channels, loaded on the output strobe.
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    gbrf_channel #(.W(16)) u_ch (
      .clk(CLK),
      .arst_n(ARST_N),
      .load(stb_r), // [RULE3]
      .raw(frame_r[i]),
      .bias(bias_vec[i]),
      .tag_en(sync_sel == gbrf_sync_e'(3'(i + 1))), // [RULE7]
      .tag_bit(fs_level_r),
      .result_r(RESULT[i])
    );
  end
  // FIFO write with the full policy; data equals the new results.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fifo_wr_r <= 1'b0;
    end
    else
    begin
      fifo_wr_r <= stb_r && (!FIFO_FULL || fifo_keep); // [RULE3] [RULE6]
    end
  end
  assign FIFO_WR = fifo_wr_r;
  assign FIFO_DATA = RESULT;
  // Bandwidth selection from bypass bits and filter select.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      gyro_bw_r <= GYRO_BW_TAB[0];
      temp_bw_r <= TEMP_BW_TAB[0];
    end
    else if (bypass_r[0])
    begin
      gyro_bw_r <= GYRO_BW_BYPASS; // [RULE9]
      temp_bw_r <= TEMP_BW_WIDE;
    end
    else if (bypass_r[1])
    begin
      gyro_bw_r <= GYRO_BW_WIDE; // [RULE9]
      temp_bw_r <= TEMP_BW_WIDE;
    end
    else
    begin
      gyro_bw_r <= GYRO_BW_TAB[lpf_sel]; // [RULE8] [RULE10]
      temp_bw_r <= TEMP_BW_TAB[lpf_sel]; // [RULE10]
    end
  end
  assign GYRO_BW_HZ = gyro_bw_r;
  assign TEMP_BW_HZ = temp_bw_r;
  // Checks on the sample path and the configuration effects.
  a_bias_split: assert property ( // [RULE1]
    @(posedge CLK) disable iff (!ARST_N)
    REG_REQ.wr && REG_REQ.addr == ADDR_Z_BIAS_HI
    |=> z_bias_r[15:8] == $past(REG_REQ.wdata))
    else $error("high bias byte not stored");
  a_bias_add: assert property ( // [RULE2]
    @(posedge CLK) disable iff (!ARST_N)
    stb_r && sync_sel != SYNC_ROT_Y
    |=> RESULT[CH_ROT_Y] == 16'($past(frame_r[CH_ROT_Y] + y_bias_r)))
    else $error("Y result lacks bias");
  a_fifo_rate: assert property ( // [RULE3]
    @(posedge CLK) disable iff (!ARST_N)
    FIFO_WR |-> $past(stb_r) && $changed(RESULT) || $past(stb_r))
    else $error("FIFO write without output strobe");
  a_div_zero: assert property ( // [RULE4]
    @(posedge CLK) disable iff (!ARST_N)
    div_eff && $stable(div_eff) && rate_div_r == 8'h00
    && div_cnt_r == 8'h00 && tick_r |=> stb_r)
    else $error("divider zero missed a tick");
  a_div_gate: assert property ( // [RULE5]
    @(posedge CLK) disable iff (!ARST_N)
    bypass_r != 2'b00 && SAMPLE_VALID |=> stb_r)
    else $error("divider acted while bypassed");
  a_fifo_drop: assert property ( // [RULE6]
    @(posedge CLK) disable iff (!ARST_N)
    stb_r && FIFO_FULL && !fifo_keep |=> !FIFO_WR)
    else $error("write into full FIFO in drop mode");
  a_fifo_keep: assert property ( // [RULE6]
    @(posedge CLK) disable iff (!ARST_N)
    stb_r && fifo_keep |=> FIFO_WR)
    else $error("write lost in keep mode");
  a_sync_tag: assert property ( // [RULE7]
    @(posedge CLK) disable iff (!ARST_N)
    stb_r && sync_sel == SYNC_ROT_X
    |=> RESULT[CH_ROT_X][0] == $past(fs_level_r))
    else $error("frame-sync tag not placed");
  a_bypass_bw: assert property ( // [RULE9]
    @(posedge CLK) disable iff (!ARST_N)
    bypass_r[0] |=> GYRO_BW_HZ == GYRO_BW_BYPASS && TEMP_BW_HZ == TEMP_BW_WIDE)
    else $error("bypass bandwidth wrong");
  a_lpf_bw: assert property ( // [RULE10]
    @(posedge CLK) disable iff (!ARST_N)
    bypass_r == 2'b00 ##1 bypass_r == 2'b00
    |-> GYRO_BW_HZ == GYRO_BW_TAB[$past(lpf_sel)])
    else $error("filter bandwidth wrong");
  c_div_strobe: cover property (
    @(posedge CLK) disable iff (!ARST_N) div_eff && stb_r);
  c_full_drop: cover property (
    @(posedge CLK) disable iff (!ARST_N) stb_r && FIFO_FULL && !fifo_keep);
  c_sync_set: cover property (
    @(posedge CLK) disable iff (!ARST_N)
    stb_r && sync_sel != SYNC_OFF && fs_level_r);
endmodule
`default_nettype wire

// ### tb/gbrf_fifo_model.sv
// Write-side model of the sample FIFO that reports full after DEPTH writes.
`default_nettype none
module gbrf_fifo_model #(
  parameter int DEPTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Write side and empty request.
  input wire logic wr,
  input wire logic clear,
  output logic full
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  // Counts stored words, including writes forced into a full FIFO.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= 0;
    else if (clear)
      cnt_r <= 0;
    else if (wr)
      cnt_r <= cnt_r + 1;
  end
  // Full is a level in the same clock domain.
  assign full = (cnt_r >= DEPTH);
endmodule
`default_nettype wire

// ### tb/gyro_bias_rate_filter_cfg_bench.sv
// Self-checking bench for the gyro bias, rate and filter block.
`default_nettype none
module gyro_bias_rate_filter_cfg_bench;
  import gbrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  gbrf_reg_req_s req = '0;
  logic [7:0] rd_data;
  logic smp_v = 1'b0;
  gbrf_frame_t raw = '0;
  logic frame_sync_input = 1'b0;
  logic clr = 1'b0;
  logic full;
  logic fifo_wr;
  gbrf_frame_t fifo_data;
  gbrf_frame_t result;
  logic [13:0] gbw;
  logic [11:0] tbw;
  int n_mismatch = 0;
  int tests_run = 0;

  gbrf_top #(.TICK_CYC(TK)) u_dut (.CLK(clk), .ARST_N(arst_n),
    .REG_REQ(req), .RD_DATA(rd_data), .SAMPLE_VALID(smp_v),
    .SAMPLE_RAW(raw), .FRAME_SYNC_INPUT(frame_sync_input), .FIFO_FULL(full),
    .FIFO_WR(fifo_wr), .FIFO_DATA(fifo_data), .RESULT(result),
    .GYRO_BW_HZ(gbw), .TEMP_BW_HZ(tbw));
  gbrf_fifo_model #(.DEPTH(1)) u_fifo (.clk(clk), .arst_n(arst_n),
    .wr(fifo_wr), .clear(clr), .full(full));

  // Free-running 8 ns clock.
  always #4 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    d = rd_data;
  endtask
  // One sample pulse; returns while the new result and its write stand.
  task automatic pulse(input gbrf_frame_t r);
    @(negedge clk);
    raw = r;
    smp_v = 1'b1;
    @(negedge clk);
    smp_v = 1'b0;
    @(negedge clk);
  endtask
  task automatic fclr();
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic wait_wr(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (fifo_wr !== 1'b1 && n < 2000);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] e;
    for (int a = 'h15; a <= 'h1b; a++)
    begin
      rd_reg(8'(a), d);
      chk(16'(d), 16'h0000);
      wr_reg(8'(a), 8'hff);
      rd_reg(8'(a), d);
      e = (a == 'h1a) ? 8'h7f : (a == 'h1b) ? 8'h03 : 8'hff;
      chk(16'(d), 16'(e));
      wr_reg(8'(a), 8'h00);
    end
    wr_reg(8'h20, 8'h5a);
    rd_reg(8'h20, d);
    chk(16'(d), 16'h0000);
    $display("registers done");
  endtask
  task automatic t_bw();
    int g[8] = '{250, 176, 92, 41, 20, 10, 5, 3281};
    int t[8] = '{4000, 188, 98, 42, 20, 10, 5, 4000};
    int bg[3] = '{8173, 3281, 8173};
    for (int s = 0; s < 8; s++)
    begin
      wr_reg(ADDR_FILT_CFG, 8'(s));
      @(negedge clk);
      chk(16'(gbw), 16'(g[s]));
      chk(16'(tbw), 16'(t[s]));
    end
    for (int b = 1; b < 4; b++)
    begin
      wr_reg(ADDR_GYRO_CFG, 8'(b));
      @(negedge clk);
      chk(16'(gbw), 16'(bg[b-1]));
      chk(16'(tbw), 16'd4000);
    end
    wr_reg(ADDR_GYRO_CFG, 8'h00);
    wr_reg(ADDR_FILT_CFG, 8'h00);
    $display("bandwidth done");
  endtask
  task automatic t_sync();
    frame_sync_input = 1'b1;
    for (int s = 1; s < 8; s++)
    begin
      wr_reg(ADDR_FILT_CFG, 8'(s << 3));
      pulse('0);
      for (int c = 0; c < NUM_CH; c++)
        chk(result[c], (c == s - 1) ? 16'h0001 : 16'h0000);
    end
    frame_sync_input = 1'b0;
    repeat (4) @(negedge clk);
    pulse('0);
    chk(result[6], 16'h0000);
    wr_reg(ADDR_FILT_CFG, 8'h00);
    $display("sync done");
  endtask
  task automatic t_bias();
    gbrf_frame_t r = '0;
    r[CH_ROT_X] = 16'h7777;
    r[CH_ROT_Y] = 16'h1000;
    r[CH_ROT_Z] = 16'h0020;
    fclr();
    wr_reg(ADDR_Y_BIAS_HI, 8'h12);
    wr_reg(ADDR_Y_BIAS_LO, 8'h34);
    wr_reg(ADDR_Z_BIAS_HI, 8'hff);
    wr_reg(ADDR_Z_BIAS_LO, 8'hf0);
    pulse(r);
    chk(result[CH_ROT_Y], 16'h2234);
    chk(result[CH_ROT_Z], 16'h0010);
    chk(result[CH_ROT_X], 16'h7777);
    chk(16'(fifo_wr), 16'h0001);
    chk(fifo_data[CH_ROT_Z], 16'h0010);
    wr_reg(ADDR_Y_BIAS_LO, 8'h00);
    pulse(r);
    chk(result[CH_ROT_Y], 16'h2200);
    $display("bias done");
  endtask
  task automatic t_fifo();
    for (int m = 0; m < 2; m++)
    begin
      wr_reg(ADDR_FILT_CFG, m ? 8'h40 : 8'h00);
      fclr();
      pulse('0);
      chk(16'(fifo_wr), 16'h0001);
      pulse('0);
      chk(16'(fifo_wr), 16'(m));
    end
    $display("fifo done");
  endtask
  task automatic t_rate();
    int n;
    logic [7:0] off[3] = '{8'h00, 8'h07, 8'h01};
    gbrf_frame_t f = '0;
    f[CH_TEMP] = 16'h0abc;
    fclr();
    wr_reg(ADDR_FILT_CFG, 8'h41);
    for (int d = 0; d < 3; d += 2)
    begin
      wr_reg(ADDR_RATE_DIV, 8'(d));
      repeat (2) wait_wr(n);
      wait_wr(n);
      chk(16'(n), 16'((d + 1) * TK));
    end
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(ADDR_GYRO_CFG, (k == 2) ? 8'h01 : 8'h00);
      wr_reg(ADDR_FILT_CFG, off[k]);
      wait_wr(n);
      chk(16'(n), 16'd2000);
    end
    // Bypassed, a sample still passes through at the native rate.
    fclr();
    pulse(f);
    chk(result[CH_TEMP], 16'h0abc);
    chk(16'(fifo_wr), 16'h0001);
    $display("rate done");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_regs();
    t_bw();
    t_sync();
    t_bias();
    t_fifo();
    t_rate();
    test_done();
  end

  // Cuts a hang short well after the scenarios should have ended.
  initial
  begin
    #200000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
